// [src/aesc_pkg.sv]
// Package of the cipher control block: addresses, field layout, codes and carriers.
// Assumes byte-wide frame-buffer accesses issued by the serial interface front end.
package aesc_pkg;

   // Byte addresses in the security address space.
   localparam logic [7:0] AESC_ADDR_STATUS = 8'h82;
   localparam logic [7:0] AESC_ADDR_CTRL   = 8'h83;
   localparam logic [7:0] AESC_ADDR_BLK_LO = 8'h84;
   localparam logic [7:0] AESC_ADDR_BLK_HI = 8'h93;
   localparam logic [7:0] AESC_ADDR_ALIAS  = 8'h94;

   // Field positions of the cipher control byte.
   localparam int AESC_CTRL_REQ_BIT  = 7;
   localparam int AESC_CTRL_MODE_HI  = 6;
   localparam int AESC_CTRL_MODE_LO  = 4;
   localparam int AESC_CTRL_DIR_BIT  = 3;

   // Field positions of the status byte.
   localparam int AESC_STAT_ERR_BIT  = 7;
   localparam int AESC_STAT_DONE_BIT = 0;

   // Reset values.
   localparam logic [2:0] AESC_MODE_RST = 3'h0;
   localparam logic       AESC_DIR_RST  = 1'b0;
   localparam logic [7:0] AESC_BYTE_RST = 8'h00;

   // Cipher mode codes; other codes are reserved.
   localparam logic [2:0] AESC_MODE_ECB = 3'h0;
   localparam logic [2:0] AESC_MODE_KEY = 3'h1;
   localparam logic [2:0] AESC_MODE_CBC = 3'h2;

   // Direction codes.
   localparam logic AESC_DIR_ENC = 1'b0;
   localparam logic AESC_DIR_DEC = 1'b1;

   // Block size in bytes.
   localparam int AESC_BLOCK_BYTES = 16;

   // One byte access from the serial front end.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aesc_acc_t;

   // Command to the cipher core.
   typedef struct packed {
      logic       start;
      logic       abort;
      logic [2:0] mode;
      logic       dir;
   } aesc_cmd_t;

   // Run state of the control block.
   typedef enum logic {
      AESC_IDLE,
      AESC_RUN
   } aesc_state_t;

endpackage

// [src/aesc_ctrl.sv]
// Control logic of the block cipher unit: control byte, alias byte, status, block store.
// Assumes a serial front end issuing one byte access per cycle while its frame level is high,
// and an external cipher core answering a start with a done pulse and a result block.
// Behaviour
// RQ1: Writing control with bit 7 starts run.
// RQ2: Request bit write-only, reads zero when idle.
// RQ3: Mode field 6:4: ECB, key load, CBC.
// RQ4: Bit 3 direction; decryption only in ECB (code also launches decryption with key load).
// RQ5: Low bits reserved zero; fields reset zero.
// RQ6: Control access during run aborts it.
// RQ7: Software polls done flag, avoids control.
// RQ8: Alias byte mirrors control exactly.
// RQ9: Alias write ends burst, starts same access.
// RQ10: Done flag set when operation finishes.
// RQ11: Error on control access or short read (code flags a control access only during a run, not when idle).
// RQ12: Block bytes hold key or data by mode.
// RQ13: Writes return previous byte one byte later.
// RQ14: Reserved mode code never starts a run.
// RQ15: Decryption with CBC starts nothing.
`timescale 1ns/1ps

module aesc_ctrl
   import aesc_pkg::*;
#(
   parameter int NUM_BYTES = AESC_BLOCK_BYTES
)(
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   srst,
   // Byte access port from the serial front end.
   input  wire logic                   acc_frame,
   input  wire aesc_acc_t              acc,
   output logic [7:0]                  acc_rdata,
   output logic                        acc_rvalid,
   // Cipher core side.
   output aesc_cmd_t                   core_cmd,
   output logic [8*NUM_BYTES-1:0]      core_key,
   output logic [8*NUM_BYTES-1:0]      core_block,
   input  wire logic                   core_done,
   input  wire logic [8*NUM_BYTES-1:0] core_result,
   // Status seen outside.
   output logic                        busy
);

   // The address decode assumes a sixteen-byte block window.
   if (NUM_BYTES != AESC_BLOCK_BYTES) begin : g_bad_size
      $error("aesc_ctrl supports only a sixteen-byte block");
   end

   // True when the address falls inside the block window.
   function automatic logic in_block(input logic [7:0] a);
      return (a >= AESC_ADDR_BLK_LO) && (a <= AESC_ADDR_BLK_HI);
   endfunction

   // Byte index inside the block window.
   function automatic logic [3:0] blk_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - AESC_ADDR_BLK_LO;
      return d[3:0];
   endfunction

   aesc_state_t      state;
   aesc_state_t      next_state;
   logic [2:0]       mode;
   logic             dir;
   logic             done_flag;
   logic             err_flag;
   logic [7:0]       key_mem   [NUM_BYTES];
   logic [7:0]       blk_mem   [NUM_BYTES];
   logic [15:0]      rd_seen;
   logic             frame_q;

   // Access decode.
   wire logic       hit_ctrl   = acc.valid && ((acc.addr == AESC_ADDR_CTRL) ||
                                               (acc.addr == AESC_ADDR_ALIAS)); // RQ8
   wire logic       hit_blk    = acc.valid && in_block(acc.addr);
   wire logic [3:0] idx        = blk_idx(acc.addr);
   wire logic       ctrl_wr    = hit_ctrl && acc.write;
   wire logic [2:0] wr_mode    = acc.wdata[AESC_CTRL_MODE_HI:AESC_CTRL_MODE_LO];
   wire logic       wr_dir     = acc.wdata[AESC_CTRL_DIR_BIT];
   wire logic       mode_legal = (wr_mode == AESC_MODE_ECB) || (wr_mode == AESC_MODE_KEY) ||
                                 (wr_mode == AESC_MODE_CBC); // RQ14
   wire logic       dir_legal  = !(wr_dir == AESC_DIR_DEC && wr_mode == AESC_MODE_CBC); // RQ15
   wire logic       abort_now  = (state == AESC_RUN) && hit_ctrl && !core_done; // RQ6
   wire logic       start_now  = (state == AESC_IDLE) && ctrl_wr &&
                                 acc.wdata[AESC_CTRL_REQ_BIT] && mode_legal && dir_legal; // RQ1
   wire logic       key_sel    = (mode == AESC_MODE_KEY); // RQ12
   wire logic       frame_end  = frame_q && !acc_frame;
   wire logic       short_read = frame_end && (rd_seen != 16'h0000) && (rd_seen != 16'hFFFF);

   // Control and status bytes as they read back; the request bit always reads zero.
   wire logic [7:0] ctrl_rd = {1'b0, mode, dir, 3'h0}; // RQ2 RQ5
   wire logic [7:0] stat_rd = {err_flag, 6'h00, done_flag};

   // Previous content of the addressed byte, returned for reads and writes alike.
   logic [7:0] old_byte;
   always_comb begin
      old_byte = AESC_BYTE_RST;
      if (acc.addr == AESC_ADDR_STATUS) begin
         old_byte = stat_rd;
      end else if ((acc.addr == AESC_ADDR_CTRL) || (acc.addr == AESC_ADDR_ALIAS)) begin
         old_byte = ctrl_rd; // RQ8
      end else if (in_block(acc.addr)) begin
         old_byte = key_sel ? key_mem[idx] : blk_mem[idx];
      end
   end

   // Run sequencing: a finish beats an abort in the same cycle.
   always_comb begin
      next_state = state;
      case (state)
         AESC_IDLE: begin
            if (start_now) begin
               next_state = AESC_RUN;
            end
         end
         AESC_RUN: begin
            if (core_done || abort_now) begin
               next_state = AESC_IDLE;
            end
         end
         default: begin
            next_state = AESC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= AESC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Mode and direction fields, written through either control address.
   always_ff @(posedge clk) begin
      if (srst) begin
         mode <= AESC_MODE_RST; // RQ5
         dir  <= AESC_DIR_RST;
      end else if (ctrl_wr) begin
         mode <= wr_mode; // RQ3
         dir  <= wr_dir; // RQ4
      end
   end

   // Done flag: cleared by a launch, set when the core finishes; the set wins.
   always_ff @(posedge clk) begin
      if (srst) begin
         done_flag <= 1'b0;
      end else if ((state == AESC_RUN) && core_done) begin
         done_flag <= 1'b1; // RQ10
      end else if (start_now) begin
         done_flag <= 1'b0;
      end
   end

   // Error flag: set on a control access mid-run or a partial block read.
   always_ff @(posedge clk) begin
      if (srst) begin
         err_flag <= 1'b0;
      end else if (abort_now || short_read) begin
         err_flag <= 1'b1; // RQ11
      end else if (start_now) begin
         err_flag <= 1'b0;
      end
   end

   // Tracks which block bytes were read during the current frame.
   always_ff @(posedge clk) begin
      if (srst) begin
         frame_q <= 1'b0;
         rd_seen <= 16'h0000;
      end else begin
         frame_q <= acc_frame;
         if (frame_end) begin
            rd_seen <= 16'h0000;
         end else if (hit_blk && !acc.write && !key_sel) begin
            rd_seen[idx] <= 1'b1;
         end
      end
   end

   // Block store; a host write always overrides a result landing in the same cycle.
   for (genvar i = 0; i < NUM_BYTES; i++) begin : g_byte
      wire logic wr_here = hit_blk && acc.write && (idx == 4'(i));
      always_ff @(posedge clk) begin
         if (srst) begin
            key_mem[i] <= AESC_BYTE_RST;
            blk_mem[i] <= AESC_BYTE_RST;
         end else if (wr_here && key_sel) begin
            key_mem[i] <= acc.wdata; // RQ12
         end else if (wr_here) begin
            blk_mem[i] <= acc.wdata;
         end else if ((state == AESC_RUN) && core_done && (mode != AESC_MODE_KEY)) begin
            blk_mem[i] <= core_result[8*i +: 8];
         end
      end
      assign core_key[8*i +: 8]   = key_mem[i];
      assign core_block[8*i +: 8] = blk_mem[i];
   end

   // Read-back path: old content leaves one cycle after the access.
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_rdata  <= AESC_BYTE_RST;
         acc_rvalid <= 1'b0;
      end else begin
         acc_rvalid <= acc.valid;
         if (acc.valid) begin
            acc_rdata <= old_byte; // RQ13
         end
      end
   end

   // Core command, registered; the alias write of a burst launches at once.
   always_ff @(posedge clk) begin
      if (srst) begin
         core_cmd <= '0;
      end else begin
         core_cmd.start <= start_now; // RQ9
         core_cmd.abort <= abort_now; // RQ6
         if (start_now) begin
            core_cmd.mode <= wr_mode;
            core_cmd.dir  <= wr_dir;
         end
      end
   end

   assign busy = (state == AESC_RUN);

endmodule

// [tb/aesc_monitor.sv]
// Checker of the cipher control block ports.
// Assumes it is bound to every instance of the control block.
`timescale 1ns/1ps
module aesc_monitor
   import aesc_pkg::*;
(
   // Watched ports.
   input wire logic       clk,
   input wire logic       srst,
   input wire aesc_acc_t  acc,
   input wire logic [7:0] acc_rdata,
   input wire logic       acc_rvalid,
   input wire aesc_cmd_t  core_cmd,
   input wire logic       core_done,
   input wire logic       busy
);
   // Control byte hits, legal settings and an idle launch request.
   wire ctl_hit = acc.valid && (acc.addr == AESC_ADDR_CTRL || acc.addr == AESC_ADDR_ALIAS);
   wire cbc_dec = acc.wdata[3] && acc.wdata[6:4] == AESC_MODE_CBC;
   wire mode_ok = acc.wdata[6:4] <= AESC_MODE_CBC && !cbc_dec;
   wire go_req  = ctl_hit && acc.write && acc.wdata[7] && !busy;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_rvalid_follows: assert property (acc.valid |=> acc_rvalid)
      else $error("No read valid after access.");
   a_start_launch: assert property (go_req && mode_ok |=> core_cmd.start && busy)
      else $error("Legal request did not launch.");
   a_start_fields: assert property (go_req && mode_ok |=> core_cmd.mode == $past(acc.wdata[6:4])
      && core_cmd.dir == $past(acc.wdata[3]))
      else $error("Launch fields wrong.");
   a_reserved_idle: assert property (go_req && !mode_ok |=> !core_cmd.start && !busy)
      else $error("Illegal setting launched.");
   a_idle_start: assert property (!go_req |=> !core_cmd.start)
      else $error("Launch without request.");
   a_abort_access: assert property (busy && !core_done && ctl_hit |=> core_cmd.abort && !busy)
      else $error("Control access did not abort.");
   a_done_ends: assert property (busy && core_done |=> !busy && !core_cmd.abort)
      else $error("Run did not finish on done.");
   a_ctrl_readback: assert property (ctl_hit && !acc.write |=> acc_rdata[7] == 1'b0
      && acc_rdata[2:0] == 3'h0)
      else $error("Control read shows write-only or reserved bits.");
endmodule
bind aesc_ctrl aesc_monitor u_mon (.clk(clk), .srst(srst), .acc(acc), .acc_rdata(acc_rdata),
   .acc_rvalid(acc_rvalid), .core_cmd(core_cmd), .core_done(core_done), .busy(busy));

// [tb/aesc_core_model.sv]
// Behavioural cipher core answering each launch that is not aborted after a fixed delay.
// Assumes start and abort arrive as one-cycle pulses.
`timescale 1ns/1ps
module aesc_core_model #(
   parameter int LAT = 4
)(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         srst,
   // Command and block from the control block.
   input  wire logic         start,
   input  wire logic         abort,
   input  wire logic [127:0] blk,
   // Answer.
   output logic              done,
   output logic [127:0]      result
);
   int cnt;
   // Counts a run down; the result bus churns so that only the done cycle is meaningful.
   always_ff @(posedge clk) begin
      done <= 1'b0;
      result <= ~result;
      if (srst || abort) begin
         cnt <= 0;
         result <= 128'h0;
      end else if (start) begin
         cnt <= LAT;
      end else if (cnt == 1) begin
         cnt <= 0;
         done <= 1'b1;
         result <= ~blk;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// [tb/aes_security_control_bench.sv]
// Self-checking bench of the cipher control block.
// Assumes the behavioural core model as the far side of the core port.
`timescale 1ns/1ps
module aes_security_control_bench
   import aesc_pkg::*;
;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic         acc_frame = 1'b1;
   aesc_acc_t    acc = '0;
   logic [7:0]   acc_rdata;
   logic         acc_rvalid, busy, core_done;
   aesc_cmd_t    core_cmd;
   logic [127:0] core_key, core_block, core_result;
   int           miscompares = 0;
   int           checks_done = 0;
   logic [16:0]  rows [8];
   always #10 clk = ~clk;
   aesc_ctrl u_dut (.clk(clk), .srst(srst), .acc_frame(acc_frame), .acc(acc),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .core_cmd(core_cmd), .core_key(core_key),
      .core_block(core_block), .core_done(core_done), .core_result(core_result), .busy(busy));
   aesc_core_model u_core (.clk(clk), .srst(srst), .start(core_cmd.start),
      .abort(core_cmd.abort), .blk(core_block), .done(core_done), .result(core_result));
   // Bus access helpers: one byte per edge, results read once the taking edge has landed.
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      acc <= '{1'b1, w, a, d};
   endtask
   task automatic gap();
      @(posedge clk);
      acc <= '0;
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      op(1'b0, a, 8'h00);
      gap();
      chk(acc_rdata, exp);
   endtask
   // Waits for the run to end before control is touched again; a run that never ends is a miss.
   task automatic wait_idle();
      for (int n = 0; n < 40 && busy !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk({7'h00, busy}, 8'h00);
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence: reset values, short read, table of control writes, then awkward cases.
   initial begin
      rows = '{{8'h83, 8'h80, 1'b1}, {8'h94, 8'h90, 1'b1}, {8'h83, 8'hA0, 1'b1},
         {8'h94, 8'h88, 1'b1}, {8'h83, 8'hA8, 1'b0}, {8'h83, 8'hB0, 1'b0},
         {8'h94, 8'hF8, 1'b0}, {8'h83, 8'h28, 1'b0}};
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(AESC_ADDR_CTRL, 8'h00);
      rd(AESC_ADDR_STATUS, 8'h00);
      rd(AESC_ADDR_BLK_LO, 8'h00);
      @(posedge clk) acc_frame <= 1'b0;
      @(posedge clk) acc_frame <= 1'b1;
      rd(AESC_ADDR_STATUS, 8'h80);
      foreach (rows[i]) begin
         op(1'b1, rows[i][16:9], rows[i][8:1]);
         gap();
         chk({7'h00, core_cmd.start}, {7'h00, rows[i][0]});
         wait_idle();
         if (rows[i][0]) rd(AESC_ADDR_STATUS, 8'h01);
         rd(rows[i][16:9], rows[i][8:1] & 8'h78);
      end
      // One burst of sixteen data bytes closed by the alias byte launches a run.
      for (int b = 0; b < 16; b++) op(1'b1, AESC_ADDR_BLK_LO + 8'(b), 8'(b));
      op(1'b1, AESC_ADDR_ALIAS, 8'h80);
      gap();
      chk({7'h00, busy}, 8'h01);
      rd(AESC_ADDR_CTRL, 8'h00);
      chk({6'h00, core_cmd.abort, busy}, 8'h02);
      rd(AESC_ADDR_STATUS, 8'h80);
      op(1'b1, AESC_ADDR_BLK_HI, 8'h3C);
      op(1'b1, AESC_ADDR_BLK_HI, 8'hC3);
      gap();
      chk(acc_rdata, 8'h3C);
      chk(core_block[127:120], 8'hC3);
      // Key mode sends block writes to the key store and leaves the data block alone.
      op(1'b1, AESC_ADDR_CTRL, 8'h10);
      op(1'b1, AESC_ADDR_BLK_LO, 8'h5A);
      gap();
      chk(core_key[7:0], 8'h5A);
      chk(core_block[7:0], 8'h00);
      rd(AESC_ADDR_BLK_LO, 8'h5A);
      // An ECB run writes the inverted block of the core model back into the data block only.
      op(1'b1, AESC_ADDR_CTRL, 8'h80);
      gap();
      wait_idle();
      chk(core_block[127:120], 8'h3C);
      chk(core_key[7:0], 8'h5A);
      rd(AESC_ADDR_STATUS, 8'h01);
      final_report();
   end
   // Watchdog against a hang.
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      final_report();
   end
endmodule
